// >>> rcs_pkg.sv
// constants for the reset and clock start-up sequencer
// Function
// - power-on-clear holds the CPU in reset
// - supply good releases reset, starts internal oscillator
// - CPU runs on internal oscillator after processing
// - crystals start only on software request
// - external clock input needs no stabilisation wait
// - analog shared pins come up in analog mode
// - low reset pin keeps device in reset
// - oscillator mode register resets to zero, pins ports
// - unselected clocks may be stopped by software
// - stop halts internal and high-speed clocks
package rcs_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int N_ANALOG = 8;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_CPU_CLK_SEL = 16'hfffb;
  localparam logic [15:0] IDX_CLK_CTRL = 16'hfff4;
  localparam logic [15:0] IDX_OSC_MODE = 16'hfff5;
  localparam logic [15:0] IDX_RST_MASK = 16'hfff6;
  localparam logic [15:0] IDX_ANALOG = 16'hfff7;
  localparam logic [15:0] IDX_STATUS = 16'hfff8;
  // reset values
  localparam logic [7:0] CPU_CLK_SEL_RST = 8'h01;
  localparam logic [7:0] CLK_CTRL_RST = 8'h00;
  localparam logic [7:0] OSC_MODE_RST = 8'h00;
  localparam logic [7:0] RST_MASK_RST = 8'h00;
  localparam logic [7:0] ANALOG_RST = 8'hff;
  // cpu clock select: divider field in low three bits
  localparam logic [7:0] CPU_CLK_SEL_WMASK = 8'h07;
  // clock control fields
  localparam int CC_MAIN_START = 0;
  localparam int CC_SUB_START = 1;
  localparam int CC_INT_STOP = 2;
  localparam int CC_SEL_MAIN = 3;
  localparam int CC_SEL_SUB = 4;
  localparam logic [7:0] CLK_CTRL_WMASK = 8'h1f;
  // oscillator mode fields
  localparam int OM_MAIN_LSB = 0;
  localparam logic [1:0] OM_PORT = 2'h0;
  localparam logic [1:0] OM_CRYSTAL = 2'h1;
  localparam logic [1:0] OM_EXT = 2'h2;
  localparam int OM_SUB_EXT = 4;
  localparam logic [7:0] OSC_MODE_WMASK = 8'h13;
  // reset mask field
  localparam int RM_PIN_MASK = 5;
  localparam logic [7:0] RST_MASK_WMASK = 8'h20;
  // status fields
  localparam int ST_INT_RUN = 0;
  localparam int ST_MAIN_OK = 1;
  localparam int ST_SUB_OK = 2;
  localparam int ST_SRC_LSB = 3;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int RESET_PROC_NS = 12000;
  localparam int RESET_PROC_CYC = (RESET_PROC_NS * CLK_MHZ + 999) / 1000;
  localparam int STAB_CYC_DEF = 4096;
  localparam int PROC_W = 12;
  localparam int STAB_W = 16;
  typedef enum logic [1:0] {
    SRC_INT = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_SUB = 2'b10
  } rcs_src_t;
  typedef enum logic [1:0] {
    SEQ_POC = 2'b00,
    SEQ_PROC = 2'b01,
    SEQ_RUN = 2'b10,
    SEQ_STOP = 2'b11
  } rcs_seq_t;
endpackage : rcs_pkg

// >>> rcs_stab_cnt.sv
// oscillator stabilisation counter with external-clock bypass
`timescale 1ns/1ps
module rcs_stab_cnt #(
  parameter int STAB_CYC = rcs_pkg::STAB_CYC_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic bypass_i,
  output logic stable_o
);
  localparam logic [rcs_pkg::STAB_W-1:0] LAST = rcs_pkg::STAB_W'(STAB_CYC - 1);
  logic [rcs_pkg::STAB_W-1:0] cnt;
  wire done = (cnt == LAST);
  wire next_stable = en_i & (bypass_i | done);
  // count restarts whenever the oscillator is disabled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      stable_o <= 1'b0;
    end else begin
      stable_o <= next_stable;
      if (!en_i) begin
        cnt <= '0;
      end else if (!done) begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : rcs_stab_cnt

// >>> rcs_top.sv
// reset and clock start-up sequencer with apb registers
`timescale 1ns/1ps
module rcs_top #(
  parameter int STAB_CYC = rcs_pkg::STAB_CYC_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [rcs_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [rcs_pkg::DATA_W-1:0] pwdata_i,
  output logic [rcs_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic supply_ok_i,
  input wire logic reset_shared_port_pin_i,
  input wire logic lowvolt_default_start_option_i,
  input wire logic stop_exec_i,
  input wire logic wake_i,
  output logic cpu_rst_n_o,
  output logic int_osc_en_o,
  output logic main_crystal_osc_en_o,
  output logic sub_crystal_osc_en_o,
  output logic [1:0] cpu_clk_src_o,
  output logic [2:0] cpu_clk_div_o,
  output logic [rcs_pkg::N_ANALOG-1:0] analog_mode_o,
  output logic osc_pins_port_o,
  output logic rst_pin_is_reset_o
);
  // byte address match for a register index
  function automatic logic hit(input logic [rcs_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  rcs_pkg::rcs_seq_t state;
  rcs_pkg::rcs_seq_t next_state;
  rcs_pkg::rcs_src_t cur_src;
  rcs_pkg::rcs_src_t next_src;
  logic [rcs_pkg::PROC_W-1:0] proc_cnt;
  logic [7:0] cpu_clk_sel;
  logic [7:0] clk_ctrl;
  logic [7:0] osc_mode;
  logic [7:0] rst_mask;
  logic [7:0] analog;
  logic main_ok;
  logic sub_ok;

  localparam logic [rcs_pkg::PROC_W-1:0] PROC_LAST = rcs_pkg::PROC_W'(rcs_pkg::RESET_PROC_CYC - 1);

  // bus decode
  wire sel_cpu = hit(paddr_i, rcs_pkg::IDX_CPU_CLK_SEL);
  wire sel_ctrl = hit(paddr_i, rcs_pkg::IDX_CLK_CTRL);
  wire sel_mode = hit(paddr_i, rcs_pkg::IDX_OSC_MODE);
  wire sel_mask = hit(paddr_i, rcs_pkg::IDX_RST_MASK);
  wire sel_an = hit(paddr_i, rcs_pkg::IDX_ANALOG);
  wire sel_stat = hit(paddr_i, rcs_pkg::IDX_STATUS);
  wire mapped = sel_cpu | sel_ctrl | sel_mode | sel_mask | sel_an | sel_stat;
  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i & mapped;
  wire [7:0] wd = pwdata_i[7:0];

  // zero wait states; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;

  // pin reset unless masked; held until the pin rises again
  wire pin_rst = ~rst_mask[rcs_pkg::RM_PIN_MASK] & ~reset_shared_port_pin_i;
  // registers return to defaults while any reset source is active
  wire clr = pin_rst | (state == rcs_pkg::SEQ_POC);
  wire [1:0] main_mode = osc_mode[rcs_pkg::OM_MAIN_LSB +: 2];
  wire main_ext = (main_mode == rcs_pkg::OM_EXT);
  wire sub_ext = osc_mode[rcs_pkg::OM_SUB_EXT];

  // the clock in cur_src cannot be switched off through the clock control register; a write in the cycle of a source switch can stop the incoming one
  wire [7:0] ctrl_w = wd & rcs_pkg::CLK_CTRL_WMASK;
  wire keep_int = (cur_src == rcs_pkg::SRC_INT);
  wire keep_main = (cur_src == rcs_pkg::SRC_MAIN);
  wire keep_sub = (cur_src == rcs_pkg::SRC_SUB);
  wire [7:0] ctrl_guard = {3'b000, ctrl_w[4:3],
                           ctrl_w[rcs_pkg::CC_INT_STOP] & ~keep_int,
                           ctrl_w[rcs_pkg::CC_SUB_START] | keep_sub,
                           ctrl_w[rcs_pkg::CC_MAIN_START] | keep_main};
  wire [7:0] next_ctrl = clr ? rcs_pkg::CLK_CTRL_RST : ((wr & sel_ctrl) ? ctrl_guard : clk_ctrl);

  // start-up sequence
  always_comb begin
    next_state = state;
    case (state)
      rcs_pkg::SEQ_POC: begin
        // slow supplies rely on the pin; the low-volt start option input is not used
        if (supply_ok_i & ~pin_rst) begin
          next_state = rcs_pkg::SEQ_PROC;
        end
      end
      rcs_pkg::SEQ_PROC: begin
        if (proc_cnt == PROC_LAST) begin
          next_state = rcs_pkg::SEQ_RUN;
        end
      end
      rcs_pkg::SEQ_RUN: begin
        if (stop_exec_i) begin
          next_state = rcs_pkg::SEQ_STOP;
        end
      end
      rcs_pkg::SEQ_STOP: begin
        if (wake_i) begin
          next_state = rcs_pkg::SEQ_RUN;
        end
      end
      default: next_state = rcs_pkg::SEQ_POC;
    endcase
    if (~supply_ok_i | pin_rst) begin
      next_state = rcs_pkg::SEQ_POC;
    end
  end

  // clock source switching to main or sub waits for that clock to be ready; internal is taken at once
  always_comb begin
    next_src = cur_src;
    if (state == rcs_pkg::SEQ_STOP && cur_src == rcs_pkg::SRC_MAIN) begin
      next_src = rcs_pkg::SRC_INT; // main clock is lost in stop
    end else if (state == rcs_pkg::SEQ_RUN) begin
      // device guards the switch even if software skips the wait
      if (clk_ctrl[rcs_pkg::CC_SEL_MAIN]) begin
        if (main_ok) begin
          next_src = rcs_pkg::SRC_MAIN;
        end
      end else if (clk_ctrl[rcs_pkg::CC_SEL_SUB]) begin
        if (sub_ok) begin
          next_src = rcs_pkg::SRC_SUB;
        end
      end else if (~clk_ctrl[rcs_pkg::CC_INT_STOP]) begin
        next_src = rcs_pkg::SRC_INT;
      end
    end
    if (clr) begin
      next_src = rcs_pkg::SRC_INT;
    end
  end

  // clock enables follow the next state so they line up with it
  wire live = (next_state == rcs_pkg::SEQ_PROC) | (next_state == rcs_pkg::SEQ_RUN);
  wire next_int_en = live & ~next_ctrl[rcs_pkg::CC_INT_STOP];
  // main crystal needs a mode chosen by software first
  wire next_main_en = live & next_ctrl[rcs_pkg::CC_MAIN_START] & (main_mode != rcs_pkg::OM_PORT);
  wire next_sub_en = (next_state != rcs_pkg::SEQ_POC) & next_ctrl[rcs_pkg::CC_SUB_START];
  wire next_run = (next_state == rcs_pkg::SEQ_RUN) | (next_state == rcs_pkg::SEQ_STOP);

  // status and read mux
  wire [7:0] status = {3'b000, cur_src, sub_ok, main_ok, int_osc_en_o};
  wire [7:0] rmux = ({8{sel_cpu}} & cpu_clk_sel) | ({8{sel_ctrl}} & clk_ctrl) |
                    ({8{sel_mode}} & osc_mode) | ({8{sel_mask}} & rst_mask) |
                    ({8{sel_an}} & analog) | ({8{sel_stat}} & status);

  // sequencer state, processing counter and outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= rcs_pkg::SEQ_POC;
      proc_cnt <= '0;
      cur_src <= rcs_pkg::SRC_INT;
      cpu_rst_n_o <= 1'b0;
      int_osc_en_o <= 1'b0;
      main_crystal_osc_en_o <= 1'b0;
      sub_crystal_osc_en_o <= 1'b0;
    end else begin
      state <= next_state;
      proc_cnt <= (state == rcs_pkg::SEQ_PROC) ? proc_cnt + 1'b1 : '0;
      cur_src <= next_src;
      cpu_rst_n_o <= next_run;
      int_osc_en_o <= next_int_en;
      main_crystal_osc_en_o <= next_main_en;
      sub_crystal_osc_en_o <= next_sub_en;
    end
  end

  // software registers, cleared by every reset source
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_clk_sel <= rcs_pkg::CPU_CLK_SEL_RST;
      clk_ctrl <= rcs_pkg::CLK_CTRL_RST;
      osc_mode <= rcs_pkg::OSC_MODE_RST;
      rst_mask <= rcs_pkg::RST_MASK_RST;
      analog <= rcs_pkg::ANALOG_RST;
    end else if (clr) begin
      cpu_clk_sel <= rcs_pkg::CPU_CLK_SEL_RST;
      clk_ctrl <= rcs_pkg::CLK_CTRL_RST;
      osc_mode <= rcs_pkg::OSC_MODE_RST;
      rst_mask <= rcs_pkg::RST_MASK_RST;
      analog <= rcs_pkg::ANALOG_RST;
    end else begin
      clk_ctrl <= next_ctrl;
      if (wr & sel_cpu) begin
        cpu_clk_sel <= wd & rcs_pkg::CPU_CLK_SEL_WMASK;
      end
      if (wr & sel_mode) begin
        osc_mode <= wd & rcs_pkg::OSC_MODE_WMASK;
      end
      if (wr & sel_mask) begin
        rst_mask <= wd & rcs_pkg::RST_MASK_WMASK;
      end
      if (wr & sel_an) begin
        analog <= wd;
      end
    end
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (psel_i & ~penable_i) begin
      prdata_o <= {24'h00_0000, rmux};
    end
  end

  // stabilisation timers for the two crystal oscillators
  rcs_stab_cnt #(.STAB_CYC(STAB_CYC)) u_main_stab (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(main_crystal_osc_en_o),
    .bypass_i(main_ext),
    .stable_o(main_ok)
  );
  rcs_stab_cnt #(.STAB_CYC(STAB_CYC)) u_sub_stab (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .en_i(sub_crystal_osc_en_o),
    .bypass_i(sub_ext),
    .stable_o(sub_ok)
  );

  // pin and clock outputs
  assign cpu_clk_src_o = cur_src;
  assign cpu_clk_div_o = cpu_clk_sel[2:0];
  assign analog_mode_o = analog;
  assign osc_pins_port_o = (main_mode == rcs_pkg::OM_PORT);
  assign rst_pin_is_reset_o = ~rst_mask[rcs_pkg::RM_PIN_MASK];

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_poc_holds_cpu: assert property (
    (state == rcs_pkg::SEQ_POC || state == rcs_pkg::SEQ_PROC) |-> !cpu_rst_n_o)
    else $error("cpu out of reset before processing ends");
  chk_release_starts_osc: assert property (
    (state == rcs_pkg::SEQ_POC && supply_ok_i && !pin_rst) |=> (state == rcs_pkg::SEQ_PROC && int_osc_en_o))
    else $error("supply good did not start internal oscillator");
  chk_run_on_internal: assert property (
    $rose(cpu_rst_n_o) |-> ($past(proc_cnt) == PROC_LAST && cur_src == rcs_pkg::SRC_INT && int_osc_en_o))
    else $error("cpu started without processing or off internal clock");
  chk_no_auto_crystal: assert property (
    !clk_ctrl[rcs_pkg::CC_MAIN_START] && !clk_ctrl[rcs_pkg::CC_SUB_START] && !wr
      |=> !main_crystal_osc_en_o && !sub_crystal_osc_en_o)
    else $error("crystal started without software request");
  chk_ext_no_wait: assert property (
    (main_crystal_osc_en_o && main_ext) |=> main_ok)
    else $error("external main clock made to wait");
  chk_analog_at_start: assert property (
    $rose(cpu_rst_n_o) |-> analog_mode_o == rcs_pkg::ANALOG_RST && rst_pin_is_reset_o)
    else $error("analog pins not in analog mode after reset");
  chk_pin_holds_reset: assert property (
    pin_rst |=> !cpu_rst_n_o [*2])
    else $error("reset pin low did not hold reset");
  chk_osc_pins_ports: assert property (
    $rose(cpu_rst_n_o) |-> osc_pins_port_o && osc_mode == rcs_pkg::OSC_MODE_RST)
    else $error("oscillator pins not ports after reset");
  chk_selected_kept: assert property (
    (state == rcs_pkg::SEQ_RUN && cur_src == rcs_pkg::SRC_MAIN && !pin_rst && supply_ok_i)
      |=> main_crystal_osc_en_o || state != rcs_pkg::SEQ_RUN)
    else $error("selected main clock was stopped");
  chk_stop_halts: assert property (
    state == rcs_pkg::SEQ_STOP |-> !int_osc_en_o && !main_crystal_osc_en_o)
    else $error("stop left a high-speed clock running");
  chk_sub_ext_nowait: assert property (
    (sub_crystal_osc_en_o && sub_ext) |=> sub_ok)
    else $error("external sub clock made to wait");
  chk_main_switch_ok: assert property (
    (cur_src != rcs_pkg::SRC_MAIN) ##1 (cur_src == rcs_pkg::SRC_MAIN) |-> $past(main_ok))
    else $error("switched to main clock before it was stable");
  chk_sub_switch_ok: assert property (
    (cur_src != rcs_pkg::SRC_SUB) ##1 (cur_src == rcs_pkg::SRC_SUB) |-> $past(sub_ok))
    else $error("switched to sub clock before it was stable");
  chk_main_ok_off: assert property (
    !main_crystal_osc_en_o |=> !main_ok)
    else $error("main clock reported stable while off");
  chk_sub_ok_off: assert property (
    !sub_crystal_osc_en_o |=> !sub_ok)
    else $error("sub clock reported stable while off");
  chk_stop_src_int: assert property (
    (state == rcs_pkg::SEQ_STOP && $past(state) == rcs_pkg::SEQ_STOP) |-> cur_src != rcs_pkg::SRC_MAIN)
    else $error("cpu left on main clock in stop");
  chk_selected_sub_kept: assert property (
    (cur_src == rcs_pkg::SRC_SUB && clk_ctrl[rcs_pkg::CC_SUB_START])
      |=> clk_ctrl[rcs_pkg::CC_SUB_START] || cur_src == rcs_pkg::SRC_INT)
    else $error("selected sub clock was stopped");
  chk_pin_clears_cfg: assert property (
    pin_rst |=> osc_pins_port_o && osc_mode == rcs_pkg::OSC_MODE_RST)
    else $error("pin reset left oscillator mode set");
  chk_pin_stops_clocks: assert property (
    pin_rst |=> cur_src == rcs_pkg::SRC_INT && !int_osc_en_o)
    else $error("pin reset left clocks running");
endmodule : rcs_top

// >>> rcs_supply_model.sv
// supply monitor and external reset source model for the sequencer
`timescale 1ns/1ps
module rcs_supply_model #(
  parameter int RAMP_CYC = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_i,
  output logic supply_ok_o,
  output logic pin_o,
  output logic lowvolt_o
);
  localparam logic [7:0] RAMP_LAST = 8'(RAMP_CYC);
  logic [7:0] ramp_cnt;
  // supply rises slowly: comparator trips only after the ramp
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ramp_cnt <= 8'h00;
    end else if (ramp_cnt < RAMP_LAST) begin
      ramp_cnt <= ramp_cnt + 8'h01;
    end
  end
  assign supply_ok_o = (ramp_cnt >= RAMP_LAST);
  // slow ramp: pin held low until supply is good, else on request
  assign pin_o = supply_ok_o && !ext_rst_i;
  // default-start option left off, sequence stays the normal one
  assign lowvolt_o = 1'b0;
endmodule : rcs_supply_model

// >>> rcs_top_tb.sv
// self-checking testbench for the reset and clock start-up sequencer
`timescale 1ns/1ps
module rcs_top_tb;
  logic core_clk_i, rst_n_i, psel, penable, pwrite, ext_rst, stop_exec, wake;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic pready, pslverr, supply_ok, pin, lowvolt, cpu_rst_n, int_osc_en, main_en, sub_en;
  logic osc_port, pin_rst;
  logic [1:0] src;
  logic [2:0] div;
  logic [7:0] analog, v;
  logic [33:0] exp_q[$];
  int bad_count, compares;
  rcs_top #(.STAB_CYC(8)) dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .supply_ok_i(supply_ok), .reset_shared_port_pin_i(pin),
    .lowvolt_default_start_option_i(lowvolt), .stop_exec_i(stop_exec), .wake_i(wake),
    .cpu_rst_n_o(cpu_rst_n), .int_osc_en_o(int_osc_en), .main_crystal_osc_en_o(main_en),
    .sub_crystal_osc_en_o(sub_en), .cpu_clk_src_o(src), .cpu_clk_div_o(div), .analog_mode_o(analog),
    .osc_pins_port_o(osc_port), .rst_pin_is_reset_o(pin_rst));
  rcs_supply_model #(.RAMP_CYC(16)) far (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ext_rst_i(ext_rst),
    .supply_ok_o(supply_ok), .pin_o(pin), .lowvolt_o(lowvolt));
  // clock
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk_sig(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t signal %h expected %h", $time, got, exp);
    end
  endtask : chk_sig
  task automatic chk_rd(input logic [33:0] e, input logic err, input logic [31:0] got);
    compares++;
    if (err !== e[32] || (e[33] && got !== e[31:0])) begin
      bad_count++;
      $display("CHECK FAILED t=%0t apb err %b data %h expected %h", $time, err, got, e);
    end
  endtask : chk_rd
  // one apb transfer; the expected answer is queued for the monitor
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d, input logic ee);
    int n;
    exp_q.push_back({!wr, ee, 24'h0000_00, d});
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0000_00, d};
    @(posedge core_clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // monitor: takes the oldest note at each completed transfer
  always @(posedge core_clk_i) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      chk_rd(exp_q.pop_front(), pslverr, prdata);
    end
  end
  task automatic wait_run();
    int n;
    n = 0;
    while (cpu_rst_n !== 1'b1 && n < 3000) begin
      @(posedge core_clk_i);
      n++;
    end
    chk_sig({7'h00, cpu_rst_n}, 8'h01);
  endtask : wait_run
  task automatic pulse(input int which);
    @(posedge core_clk_i);
    if (which == 0) stop_exec <= 1'b1;
    else wake <= 1'b1;
    @(posedge core_clk_i);
    stop_exec <= 1'b0;
    wake <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask : pulse
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk_i);
    bad_count++;
    summarize();
  end
  initial begin
    rst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 18'h0_0000;
    pwdata = 32'h0000_0000; ext_rst = 1'b0; stop_exec = 1'b0; wake = 1'b0;
    seed = 32'h0000_0024; bad_count = 0; compares = 0;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    chk_sig({6'h00, cpu_rst_n, int_osc_en}, 8'h00);
    chk_sig({4'h0, osc_port, pin_rst, main_en, sub_en}, 8'h0c);
    chk_sig({5'h00, div}, 8'h01);
    chk_sig(analog, 8'hff);
    repeat (16) @(posedge core_clk_i);
    chk_sig({7'h00, int_osc_en}, 8'h01);
    wait_run();
    chk_sig({3'h0, main_en, sub_en, src, int_osc_en}, 8'h01);
    apb(1'b0, rcs_pkg::IDX_CPU_CLK_SEL, 8'h01, 1'b0);
    apb(1'b0, rcs_pkg::IDX_OSC_MODE, 8'h00, 1'b0);
    apb(1'b0, rcs_pkg::IDX_RST_MASK, 8'h00, 1'b0);
    apb(1'b0, 16'hfff0, 8'h00, 1'b1);
    for (int i = 0; i < 3; i++) begin
      v = 8'(xs());
      apb(1'b1, rcs_pkg::IDX_ANALOG, v, 1'b0);
      apb(1'b0, rcs_pkg::IDX_ANALOG, v, 1'b0);
      chk_sig(analog, v);
    end
    // divider field keeps only its low three bits
    apb(1'b1, rcs_pkg::IDX_CPU_CLK_SEL, v, 1'b0);
    apb(1'b0, rcs_pkg::IDX_CPU_CLK_SEL, v & rcs_pkg::CPU_CLK_SEL_WMASK, 1'b0);
    chk_sig({5'h00, div}, v & rcs_pkg::CPU_CLK_SEL_WMASK);
    // crystal mode alone must not start the oscillator
    apb(1'b1, rcs_pkg::IDX_OSC_MODE, 8'h01, 1'b0);
    @(posedge core_clk_i);
    chk_sig({6'h00, main_en, osc_port}, 8'h00);
    apb(1'b1, rcs_pkg::IDX_CLK_CTRL, 8'h01, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk_sig({5'h00, main_en, src}, 8'h04);
    // software waits out the stabilisation time before selecting main
    repeat (12) @(posedge core_clk_i);
    apb(1'b0, rcs_pkg::IDX_STATUS, 8'h03, 1'b0);
    apb(1'b1, rcs_pkg::IDX_CLK_CTRL, 8'h09, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk_sig({6'h00, src}, 8'h01);
    // sub clock as external input switches in without the long wait
    apb(1'b1, rcs_pkg::IDX_OSC_MODE, 8'h11, 1'b0);
    apb(1'b1, rcs_pkg::IDX_CLK_CTRL, 8'h12, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk_sig({6'h00, src}, 8'h02);
    apb(1'b1, rcs_pkg::IDX_CLK_CTRL, 8'h17, 1'b0);
    repeat (2) @(posedge core_clk_i);
    chk_sig({6'h00, main_en, int_osc_en}, 8'h02);
    pulse(0);
    chk_sig({6'h00, main_en, int_osc_en}, 8'h00);
    pulse(1);
    // the selected sub clock cannot be stopped, the idle main one can
    apb(1'b1, rcs_pkg::IDX_CLK_CTRL, 8'h14, 1'b0);
    apb(1'b0, rcs_pkg::IDX_CLK_CTRL, 8'h16, 1'b0);
    chk_sig({6'h00, main_en, sub_en}, 8'h01);
    // masked pin: a low level must not reset the device
    apb(1'b1, rcs_pkg::IDX_RST_MASK, 8'h20, 1'b0);
    @(posedge core_clk_i);
    chk_sig({7'h00, pin_rst}, 8'h00);
    @(posedge core_clk_i);
    ext_rst <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    chk_sig({7'h00, cpu_rst_n}, 8'h01);
    ext_rst <= 1'b0;
    apb(1'b1, rcs_pkg::IDX_RST_MASK, 8'h00, 1'b0);
    @(posedge core_clk_i);
    ext_rst <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    chk_sig({7'h00, cpu_rst_n}, 8'h00);
    chk_sig({6'h00, osc_port, pin_rst}, 8'h03);
    chk_sig(analog, 8'hff);
    ext_rst <= 1'b0;
    wait_run();
    apb(1'b0, rcs_pkg::IDX_OSC_MODE, 8'h00, 1'b0);
    // external main clock switches in without the stabilisation wait
    apb(1'b1, rcs_pkg::IDX_OSC_MODE, 8'h02, 1'b0);
    apb(1'b1, rcs_pkg::IDX_CLK_CTRL, 8'h09, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk_sig({5'h00, main_en, src}, 8'h05);
    repeat (3) @(posedge core_clk_i);
    summarize();
  end
endmodule : rcs_top_tb
